/* design/twi_ctrl_pkg.sv */
/*
 * Constants shared by the two-wire bus controller core: register offsets,
 * control bit positions, reset values, bus state codes and filter length.
 * Assumes a 32-bit AHB-Lite register bus and word-aligned registers.
 */
`default_nettype none

package twi_ctrl_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] OFF_CTRL_SET   = 5'h00;
	localparam logic [4:0] OFF_BUS_STATE  = 5'h04;
	localparam logic [4:0] OFF_SHIFT_BYTE = 5'h08;
	localparam logic [4:0] OFF_CLK_HIGH   = 5'h10;
	localparam logic [4:0] OFF_CLK_LOW    = 5'h14;
	localparam logic [4:0] OFF_CTRL_CLEAR = 5'h18;

	// ---------------------------------------------------------------
	// Control word bit positions
	// ---------------------------------------------------------------
	localparam int BIT_ACK_ASSERT = 2;
	localparam int BIT_EVENT      = 3;
	localparam int BIT_HALT       = 4;
	localparam int BIT_BEGIN      = 5;
	localparam int BIT_ENABLE     = 6;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_CTRL      = 8'h00;
	localparam logic [7:0]  RST_SHIFT     = 8'h00;
	localparam logic [15:0] RST_CLK_HIGH  = 16'h0004;
	localparam logic [15:0] RST_CLK_LOW   = 16'h0004;

	// ---------------------------------------------------------------
	// Five-bit bus state codes (register shows code times eight)
	// ---------------------------------------------------------------
	localparam logic [4:0] SC_START     = 5'h01;
	localparam logic [4:0] SC_RESTART   = 5'h02;
	localparam logic [4:0] SC_AW_ACK    = 5'h03;
	localparam logic [4:0] SC_AW_NACK   = 5'h04;
	localparam logic [4:0] SC_DW_ACK    = 5'h05;
	localparam logic [4:0] SC_DW_NACK   = 5'h06;
	localparam logic [4:0] SC_ARB_LOST  = 5'h07;
	localparam logic [4:0] SC_AR_ACK    = 5'h08;
	localparam logic [4:0] SC_AR_NACK   = 5'h09;
	localparam logic [4:0] SC_DR_ACK    = 5'h0A;
	localparam logic [4:0] SC_DR_NACK   = 5'h0B;
	localparam logic [4:0] SC_NO_INFO   = 5'h1F;

	// Samples that must agree before a line level is accepted
	localparam int FILTER_LEN = 3;

	// Index of the acknowledge slot, the last of nine bit slots per byte
	localparam logic [3:0] LAST_SLOT = 4'h8;

endpackage

`default_nettype wire

/* design/twi_ctrl_core.sv */
/*
 * Two-wire bus master control and status core with AHB-Lite register slave.
 * Holds the set/clear control word, the latched bus state code, the shift
 * byte and the programmable serial clock generator for master modes.
 * Assumes open-drain pads outside: an enable high pulls the line low.
 */
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`default_nettype none

module twi_ctrl_core
	import twi_ctrl_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hwdata,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_scl,
	output logic             o_scl,
	output logic             o_scl_oe,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe,
	output logic             o_irq
);

	typedef enum logic [9:0] {
		S_IDLE    = 10'b00_0000_0001,
		S_START   = 10'b00_0000_0010,
		S_HOLD    = 10'b00_0000_0100,
		S_LOW     = 10'b00_0000_1000,
		S_HIGH    = 10'b00_0001_0000,
		S_RS_LOW  = 10'b00_0010_0000,
		S_RS_HIGH = 10'b00_0100_0000,
		S_SP_LOW  = 10'b00_1000_0000,
		S_SP_HIGH = 10'b01_0000_0000,
		S_SP_END  = 10'b10_0000_0000
	} phase_e;

	// ---------------------------------------------------------------
	// Input synchronisers and spike filters
	// ---------------------------------------------------------------
	logic [1:0]            scl_sync;
	logic [1:0]            sda_sync;
	logic [FILTER_LEN-1:0] scl_hist;
	logic [FILTER_LEN-1:0] sda_hist;
	logic                  scl_f;
	logic                  sda_f;
	logic                  sda_f_d;

	// Second stage feeds the history; the first stage is read by nothing else
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
			scl_hist <= '1;
			sda_hist <= '1;
		end else begin
			scl_sync <= {scl_sync[0], i_scl};
			sda_sync <= {sda_sync[0], i_sda};
			scl_hist <= {scl_hist[FILTER_LEN-2:0], scl_sync[1]};
			sda_hist <= {sda_hist[FILTER_LEN-2:0], sda_sync[1]};
		end
	end

	// A level is taken only after it stood for three samples
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			scl_f   <= 1'b1;
			sda_f   <= 1'b1;
			sda_f_d <= 1'b1;
		end else begin
			if (&scl_hist || ~|scl_hist) scl_f <= scl_hist[0];
			if (&sda_hist || ~|sda_hist) sda_f <= sda_hist[0];
			sda_f_d <= sda_f;
		end
	end

	// ---------------------------------------------------------------
	// AHB-Lite slave: zero wait states, always OKAY
	// ---------------------------------------------------------------
	logic       ph_write;
	logic       ph_read;
	logic [4:0] ph_addr;

	wire addr_take = i_hsel & i_htrans[1] & i_hready;
	wire hi_zero   = ~|i_haddr[31:5];

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph_write <= 1'b0;
			ph_read  <= 1'b0;
			ph_addr  <= 5'h00;
		end else begin
			ph_write <= addr_take & i_hwrite & hi_zero;
			ph_read  <= addr_take & ~i_hwrite & hi_zero;
			ph_addr  <= i_haddr[4:0];
		end
	end

	wire wr_set   = ph_write & (ph_addr == OFF_CTRL_SET);
	wire wr_clr   = ph_write & (ph_addr == OFF_CTRL_CLEAR);
	wire wr_shift = ph_write & (ph_addr == OFF_SHIFT_BYTE);
	wire wr_high  = ph_write & (ph_addr == OFF_CLK_HIGH);
	wire wr_low   = ph_write & (ph_addr == OFF_CLK_LOW);
	wire [7:0] wbyte = i_hwdata[7:0];

	// ---------------------------------------------------------------
	// Registers and bus engine state
	// ---------------------------------------------------------------
	logic [7:0]  ctrl_word;
	logic [7:0]  shift_byte;
	logic [15:0] clk_high;
	logic [15:0] clk_low;
	logic [4:0]  state_code;
	phase_e      phase;
	phase_e      next_phase;
	logic [15:0] cnt;
	logic [3:0]  slot;
	logic        rx_mode;
	logic        addr_byte;
	logic        busy;

	wire enable   = ctrl_word[BIT_ENABLE];
	wire begin_rq = ctrl_word[BIT_BEGIN];
	wire halt_rq  = ctrl_word[BIT_HALT];
	wire event_f  = ctrl_word[BIT_EVENT];
	wire ack_en   = ctrl_word[BIT_ACK_ASSERT];

	// Status reads as the code in the top five bits, zeros below
	wire [7:0] status_rd = event_f ? {state_code, 3'b000} : {SC_NO_INFO, 3'b000};

	// Read mux; unmapped offsets and the clear port read zero
	assign o_hrdata =
		!ph_read                      ? 32'h0000_0000 :
		(ph_addr == OFF_CTRL_SET)     ? {24'h00_0000, ctrl_word} :
		(ph_addr == OFF_BUS_STATE)    ? {24'h00_0000, status_rd} :
		(ph_addr == OFF_SHIFT_BYTE)   ? {24'h00_0000, shift_byte} :
		(ph_addr == OFF_CLK_HIGH)     ? {16'h0000, clk_high} :
		(ph_addr == OFF_CLK_LOW)      ? {16'h0000, clk_low} : 32'h0000_0000;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	// ---------------------------------------------------------------
	// Phase timing: low phase counts, high phase waits for the line
	// ---------------------------------------------------------------
	wire scl_phase_high = (phase == S_START) | (phase == S_HIGH) | (phase == S_RS_HIGH) |
		(phase == S_SP_HIGH) | (phase == S_SP_END);
	wire [15:0] tgt = scl_phase_high ? clk_high : clk_low;
	// A slow slave holds the high phase off; a faster master cuts it short
	wire early_low  = (phase == S_HIGH) & ~scl_f & (cnt != 16'h0000);
	wire phase_done = (cnt >= tgt) | early_low;
	wire counting   = ~scl_phase_high | scl_f;

	// Bus line decoding
	wire start_seen = scl_f & sda_f_d & ~sda_f;
	wire stop_seen  = scl_f & ~sda_f_d & sda_f;
	wire data_slot  = slot != LAST_SLOT;
	// Receive applies only after the address byte, which is always sent
	wire rx_data    = rx_mode & ~addr_byte;
	// Transmit drives the MSB, receive releases data and drives ack from ack bit
	wire sda_bit    = data_slot ? (rx_data ? 1'b1 : shift_byte[7]) : (rx_data ? ~ack_en : 1'b1);
	wire sample     = (phase == S_HIGH) & phase_done;
	// Released a one but the line reads low
	wire arb_lost   = sample & sda_bit & ~sda_f & (data_slot | rx_data);
	wire byte_end   = sample & ~arb_lost & ~data_slot;
	wire go_start   = (phase == S_IDLE) & enable & begin_rq & ~event_f & ~busy & ~halt_rq;
	wire leave_hold = (phase == S_HOLD) & ~event_f;
	wire stop_done  = (phase == S_SP_END) & phase_done;

	// Next phase of the master engine
	always_comb begin
		next_phase = phase;
		case (phase)
			S_IDLE:    if (go_start) next_phase = S_START;
			S_START:   if (phase_done) next_phase = S_HOLD;
			S_HOLD: begin
				if (!event_f) begin
					if (halt_rq) next_phase = S_SP_LOW;
					else if (begin_rq) next_phase = S_RS_LOW;
					else next_phase = S_LOW;
				end
			end
			S_LOW:     if (phase_done) next_phase = S_HIGH;
			S_HIGH: begin
				if (arb_lost) next_phase = S_IDLE;
				else if (sample) next_phase = data_slot ? S_LOW : S_HOLD;
			end
			S_RS_LOW:  if (phase_done) next_phase = S_RS_HIGH;
			S_RS_HIGH: if (phase_done) next_phase = S_START;
			S_SP_LOW:  if (phase_done) next_phase = S_SP_HIGH;
			S_SP_HIGH: if (phase_done) next_phase = S_SP_END;
			S_SP_END:  if (phase_done) next_phase = S_IDLE;
			default:   next_phase = S_IDLE;
		endcase
		if (!enable) next_phase = S_IDLE;
	end

	// Phase register and its cycle counter
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			phase <= S_IDLE;
			cnt   <= 16'h0000;
		end else begin
			phase <= next_phase;
			if (next_phase != phase) cnt <= 16'h0000;
			else if (counting && cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
		end
	end

	// Bus busy tracking between start and stop conditions
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) busy <= 1'b0;
		else if (!enable) busy <= 1'b0;
		else if (start_seen) busy <= 1'b1;
		else if (stop_seen) busy <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Shift byte, slot counter and transfer direction
	// ---------------------------------------------------------------
	// The byte shifts in whatever the bus carries, so it holds the last bus byte
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			shift_byte <= RST_SHIFT;
			slot       <= 4'h0;
			rx_mode    <= 1'b0;
			addr_byte  <= 1'b0;
		end else begin
			if (sample && data_slot) shift_byte <= {shift_byte[6:0], sda_f};
			else if (wr_shift && (event_f || phase == S_IDLE)) shift_byte <= wbyte;
			if (leave_hold) slot <= 4'h0;
			else if (sample) slot <= slot + 4'h1;
			if (phase == S_START) addr_byte <= 1'b1;
			else if (byte_end) addr_byte <= 1'b0;
			// Direction bit of the address byte picks transmit or receive
			if (leave_hold && addr_byte && !halt_rq && !begin_rq) rx_mode <= shift_byte[0];
			else if (phase == S_IDLE) rx_mode <= 1'b0;
		end
	end

	// Code reported after each byte and its acknowledge
	wire [4:0] byte_code = addr_byte
		? (rx_mode ? (sda_f ? SC_AR_NACK : SC_AR_ACK) : (sda_f ? SC_AW_NACK : SC_AW_ACK))
		: (rx_mode ? (sda_f ? SC_DR_NACK : SC_DR_ACK) : (sda_f ? SC_DW_NACK : SC_DW_ACK));
	wire       start_end = (phase == S_START) & phase_done;
	wire       hw_event  = start_end | byte_end | arb_lost;
	logic      busy_rep;
	wire [4:0] new_code  = arb_lost ? SC_ARB_LOST :
		start_end ? (busy_rep ? SC_RESTART : SC_START) : byte_code;

	// Repeated start is a start issued while this master still owns the bus
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) busy_rep <= 1'b0;
		else if (phase == S_RS_LOW) busy_rep <= 1'b1;
		else if (phase == S_IDLE) busy_rep <= 1'b0;
	end

	// Code is captured on every hardware event, the same cycle that sets the flag, even if the flag is already set
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) state_code <= SC_NO_INFO;
		else if (hw_event) state_code <= new_code;
	end

	// ---------------------------------------------------------------
	// Control word: set port, clear port, hardware set and clear
	// ---------------------------------------------------------------
	wire [7:0] sw_set = wr_set ? (wbyte & 8'h7C) : 8'h00;
	wire [7:0] sw_clr = wr_clr ? (wbyte & 8'h7C) : 8'h00;
	// Halt clears once the stop is out, or at once if not master
	wire hw_halt_clr = stop_done | ((phase == S_IDLE) & halt_rq & ~go_start);
	wire [7:0] hw_clr = {3'b000, hw_halt_clr, 4'h0};
	wire [7:0] hw_set = {4'h0, hw_event, 3'b000};
	// Hardware set of the event flag wins over a software clear in the same cycle
	wire [7:0] next_ctrl = (((ctrl_word | sw_set) & ~sw_clr) & ~hw_clr) | hw_set;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) ctrl_word <= RST_CTRL;
		else ctrl_word <= next_ctrl;
	end

	// Clock period counts; zero behaves as one cycle
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			clk_high <= RST_CLK_HIGH;
			clk_low  <= RST_CLK_LOW;
		end else begin
			if (wr_high) clk_high <= i_hwdata[15:0];
			if (wr_low) clk_low <= i_hwdata[15:0];
		end
	end

	// ---------------------------------------------------------------
	// Pin drive: enable high pulls the line low
	// ---------------------------------------------------------------
	// Slave operation is never entered, so the ack bit only shapes master acks
	wire scl_pull = (phase == S_HOLD) | (phase == S_LOW) | (phase == S_RS_LOW) |
		(phase == S_SP_LOW);
	logic start_hold;
	// After a byte the data line is released while the clock is held low
	wire addr_byte_pending_release = ~start_hold;
	wire sda_pull = (phase == S_START) | (phase == S_HOLD & ~addr_byte_pending_release) |
		((phase == S_LOW | phase == S_HIGH) & ~sda_bit) | (phase == S_SP_LOW) |
		(phase == S_SP_HIGH);

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) start_hold <= 1'b0;
		else if (start_end) start_hold <= 1'b1;
		else if (byte_end || phase == S_IDLE) start_hold <= 1'b0;
	end

	// Output flops keep pad enables glitch free
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_scl_oe <= 1'b0;
			o_sda_oe <= 1'b0;
			o_irq    <= 1'b0;
		end else begin
			o_scl_oe <= scl_pull & enable;
			o_sda_oe <= sda_pull & enable;
			o_irq    <= next_ctrl[BIT_EVENT] & next_ctrl[BIT_ENABLE];
		end
	end

	assign o_scl = 1'b0;
	assign o_sda = 1'b0;

endmodule

`default_nettype wire

/* tb/twi_ctrl_assertions.sv */
/*
 * Checker for the two-wire controller core: register reads, line and flag timing.
 * Assumes low clock counts of 3 or more and a single open-drain slave on the wires.
 */
`default_nettype none

module twi_ctrl_checker (
	input wire logic        i_core_clk,
	input wire logic        i_arst_n,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [31:0] o_hrdata,
	input wire logic        o_scl_oe,
	input wire logic        o_sda_oe,
	input wire logic        o_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	// ---------------------------------------------------------------
	// Request decode
	// ---------------------------------------------------------------
	// Status read and any write seen in an address phase
	wire st_rd  = i_hsel && i_htrans[1] && !i_hwrite && i_haddr == 32'h0000_0004;
	wire wr_req = i_hsel && i_htrans[1] && i_hwrite;

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	a_reset_quiet: assert property ($rose(i_arst_n) |-> !o_irq && !o_scl_oe && !o_sda_oe)
		else $error("outputs active after reset");
	a_status_low_zero: assert property ($past(st_rd) |-> o_hrdata[2:0] == 3'h0)
		else $error("status low bits not zero");
	a_flag_holds_clock: assert property ($fell(o_scl_oe) |-> !o_irq)
		else $error("clock released while flag set");
	a_flag_freezes_data: assert property (o_irq && $past(o_irq) |-> $stable(o_sda_oe))
		else $error("data line moved while flag set");
	a_start_raises_flag: assert property ($rose(o_sda_oe) && !o_scl_oe |-> ##[1:60] o_irq)
		else $error("no flag after start");
	a_stop_stays_idle: assert property ($fell(o_sda_oe) && !o_scl_oe |-> !o_irq [*4])
		else $error("flag raised after stop");
	a_low_phase_min: assert property ($rose(o_scl_oe) |-> o_scl_oe [*4])
		else $error("clock low phase too short");
	a_irq_fall_write: assert property ($fell(o_irq) |-> $past(wr_req, 2))
		else $error("irq fell without a write");

	c_event: cover property ($rose(o_irq));
	c_start: cover property ($rose(o_sda_oe) && !o_scl_oe);
	c_stop: cover property ($fell(o_sda_oe) && !o_scl_oe);
endmodule

`default_nettype wire

/* tb/twi_slave_model.sv */
/*
 * Behavioural slave on the two-wire bus: shifts in bytes, acks on request.
 * Assumes pull-ups on both lines; the model only ever pulls low.
 */
`default_nettype none

module twi_slave_model (
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_ack_en,
	input  wire logic       i_stretch,
	output logic            o_sda_low,
	output logic            o_scl_low,
	output logic      [7:0] o_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	int         n = 0;
	logic [7:0] sh = 8'h00;

	initial begin
		o_sda_low = 1'b0;
		o_scl_low = 1'b0;
		o_byte    = 8'h00;
	end

	// Start resets the bit count
	always @(negedge i_sda) begin
		if (i_scl) begin
			n = 0;
		end
	end

	// Sample while the clock is high, first bit is the top bit
	always @(posedge i_scl) begin
		if (n < 8) begin
			sh = {sh[6:0], i_sda};
		end
		n = n + 1;
		if (n == 8) begin
			o_byte = sh;
		end
	end

	// Ack slot driven low; stretch after the byte to test clock sync
	always @(negedge i_scl) begin
		o_sda_low = (n == 8) && i_ack_en;
		if (n == 9) begin
			n = 0;
			if (i_stretch) begin
				o_scl_low = 1'b1;
				#3000 o_scl_low = 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

/* tb/twi_ctrl_core_bench.sv */
/*
 * Self-checking bench for the two-wire controller core.
 * Assumes open-drain wires with pull-ups and a zero-wait register slave.
 */
`default_nettype none

module twi_ctrl_core_bench import twi_ctrl_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, glitch = 0, ack_en = 0, stretch = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic        hready, scl_oe, sda_oe, irq, s_sda_low, s_scl_low;
	logic [7:0]  s_byte;
	wire         scl_w, sda_w;
	int          n_fail = 0, checks = 0, run = 0, min_low = 99;

	always #50 clk = ~clk;
	// Open-drain wires: any party pulling wins
	assign scl_w = !(scl_oe || s_scl_low);
	assign sda_w = !(sda_oe || s_sda_low || glitch);

	twi_ctrl_core dut_u (.i_core_clk(clk), .i_arst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hready),
		.i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
		.i_scl(scl_w), .o_scl(), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda(),
		.o_sda_oe(sda_oe), .o_irq(irq));
	twi_slave_model slv_u (.i_scl(scl_w), .i_sda(sda_w), .i_ack_en(ack_en),
		.i_stretch(stretch), .o_sda_low(s_sda_low), .o_scl_low(s_scl_low), .o_byte(s_byte));

	// Shortest driven low phase, to compare with the programmed count
	always @(posedge clk) begin
		if (scl_oe) begin
			run <= run + 1;
		end else begin
			if (run > 0 && run < min_low) min_low <= run;
			run <= 0;
		end
	end

	// ---------------------------------------------------------------
	// Bus and check helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	// One single transfer; waits on hready in both phases
	task automatic ahb(input logic [4:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= 32'(a);
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rv = hrdata;
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		ahb(a, 1'b0, 32'h0);
		chk(rv, e);
	endtask

	task automatic wait_irq;
		int k;
		k = 0;
		repeat (2) @(posedge clk);
		while (irq !== 1'b1 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		chk({31'h0, irq}, 32'h1);
	endtask

	task automatic stop_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		rdc(OFF_CTRL_SET, 32'(RST_CTRL));
		rdc(OFF_BUS_STATE, 32'h0000_00F8);
		rdc(OFF_CLK_HIGH, 32'(RST_CLK_HIGH));
		rdc(OFF_CLK_LOW, 32'(RST_CLK_LOW));
		rdc(OFF_SHIFT_BYTE, 32'(RST_SHIFT));
		rdc(5'h1C, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_setclr;
		ahb(OFF_CTRL_SET, 1'b1, 32'h0000_00C7);
		rdc(OFF_CTRL_SET, 32'h0000_0044);
		ahb(OFF_CTRL_SET, 1'b1, 32'h0000_0008);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		ahb(OFF_CTRL_CLEAR, 1'b1, 32'h0000_0008);
		rdc(OFF_CTRL_SET, 32'h0000_0044);
		ahb(OFF_CTRL_CLEAR, 1'b1, 32'h0000_0000);
		rdc(OFF_CTRL_SET, 32'h0000_0044);
		chk({31'h0, irq}, 32'h0);
		$display("test set clear done");
	endtask

	// Address byte with ack, restart, read address with nack, then stop
	task automatic t_master;
		ahb(OFF_CLK_HIGH, 1'b1, 32'h3);
		ahb(OFF_CLK_LOW, 1'b1, 32'h3);
		glitch <= 1'b1;
		repeat (2) @(posedge clk);
		glitch <= 1'b0;
		repeat (10) @(posedge clk);
		ahb(OFF_CTRL_SET, 1'b1, 32'h0000_0020);
		wait_irq();
		rdc(OFF_BUS_STATE, 32'h0000_0008);
		rdc(OFF_CTRL_SET, 32'h0000_006C);
		ahb(OFF_SHIFT_BYTE, 1'b1, 32'h0000_00A0);
		ack_en <= 1'b1;
		min_low <= 99;
		ahb(OFF_CTRL_CLEAR, 1'b1, 32'h0000_0028);
		wait_irq();
		rdc(OFF_BUS_STATE, 32'h0000_0018);
		chk(32'(s_byte), 32'h0000_00A0);
		chk(32'(min_low), 32'h4);
		rdc(OFF_SHIFT_BYTE, 32'h0000_00A0);
		rdc(OFF_BUS_STATE, 32'h0000_0018);
		ahb(OFF_CTRL_SET, 1'b1, 32'h0000_0020);
		ahb(OFF_CTRL_CLEAR, 1'b1, 32'h0000_0008);
		wait_irq();
		rdc(OFF_BUS_STATE, 32'h0000_0010);
		ahb(OFF_SHIFT_BYTE, 1'b1, 32'h0000_00A1);
		ack_en <= 1'b0;
		stretch <= 1'b1;
		ahb(OFF_CTRL_CLEAR, 1'b1, 32'h0000_0028);
		wait_irq();
		rdc(OFF_BUS_STATE, 32'h0000_0048);
		chk(32'(s_byte), 32'h0000_00A1);
		ahb(OFF_CTRL_SET, 1'b1, 32'h0000_0010);
		ahb(OFF_CTRL_CLEAR, 1'b1, 32'h0000_0008);
		rv = 32'h0000_0010;
		for (int k = 0; k < 50 && rv[4] !== 1'b0; k++) ahb(OFF_CTRL_SET, 1'b0, 32'h0);
		rdc(OFF_CTRL_SET, 32'h0000_0044);
		repeat (20) @(posedge clk);
		chk({30'h0, scl_w, sda_w}, 32'h3);
		$display("test master done");
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_setclr();
		t_master();
		stop_test();
	end

	// Whole run needs well under 5000 cycles
	initial begin
		#2000000;
		n_fail++;
		stop_test();
	end
endmodule

bind twi_ctrl_core twi_ctrl_checker chk_u (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
	.i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
	.o_hrdata(o_hrdata), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_irq(o_irq));

`default_nettype wire
